// >>> pwmosc_pkg.sv
// pwmosc package: constants and state type for the pwm oscillator control block
package pwmosc_pkg;

	// ----------------------------------------------------------------
	// clock and frequency constants
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ       = 50_000_000;
	localparam longint      RATE_CONST_OHM_HZ = 64'd12_450_000_000; // fosc = const / r_ohm
	localparam int unsigned RATE_MASTER_MIN_OHM = 26_000;          // master above this
	localparam int unsigned SPREAD_LO_PERMIL = 950;
	localparam int unsigned SPREAD_HI_PERMIL = 1050;
	localparam int unsigned HOP_DOWN_PERMIL  = 900;
	localparam int unsigned HOP_UP_PERMIL    = 1100;
	localparam int unsigned NOMINAL_PERMIL   = 1000;
	localparam int unsigned SPREAD_STEP_PERMIL = 1;
	// spread sweep: one permil step per this many sys cycles
	localparam int unsigned SPREAD_DWELL_CYC = 16'd2000;
	// watchdog time: incoming clock absent this long means failed
	localparam int unsigned WDOG_TIME_US     = 20;
	localparam int unsigned WDOG_CYC         = WDOG_TIME_US * (SYS_CLK_HZ / 1_000_000);

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int RATE_W   = 24;  // resistance in ohm
	localparam int PERIOD_W = 24;  // period in sys cycles, fixed point 8 fraction bits
	localparam int FRAC_W   = 8;
	localparam int PERMIL_W = 11;
	localparam int WDOG_W   = 16;
	localparam int DWELL_W  = 16;

	localparam logic [PERMIL_W-1:0] PERMIL_NOM = 11'h3e8;
	localparam logic [PERMIL_W-1:0] PERMIL_SLO = 11'h3b6;
	localparam logic [PERMIL_W-1:0] PERMIL_SHI = 11'h41a;
	localparam logic [PERMIL_W-1:0] PERMIL_HLO = 11'h384;
	localparam logic [PERMIL_W-1:0] PERMIL_HHI = 11'h44c;

	typedef enum logic [1:0] {
		PWMOSC_OFF,
		PWMOSC_RUN,
		PWMOSC_STOPPING
	} pwmosc_state_type;

endpackage : pwmosc_pkg

// >>> pwmosc_edge.sv
// pwmosc edge finder: two-flop synchroniser and rising edge pulse for a pin
`timescale 1ns/10ps
module pwmosc_edge
	import pwmosc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} pwmosc_edge_type;

	pwmosc_edge_type st_q;
	pwmosc_edge_type st_d;

	// ----------------------------------------------------------------
	// synchroniser; only s2 and s3 feed logic
	// ----------------------------------------------------------------
	always_comb begin
		st_d    = st_q;
		st_d.s1 = pin_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.s2;
	assign rise  = st_q.s2 & ~st_q.s3;

endmodule : pwmosc_edge

// >>> pwmosc_ctrl.sv
// pwmosc control: master/slave oscillator, spread, hop and slave watchdog
//
// Function
// - pwm period equals one oscillator period
// - rate resistor above 26k: master, drive pin
// - rate pin grounded: slave, pin is input
// - master nominal frequency 12.45e9 over ohms
// - spread/hop master only, lock/stagger slave only
// - slave arms clock watchdog on enable low
// - stopped slave clock after enable low forces off state
// - spread pin grounded disables, capacitor enables
// - spread sweeps triangle 0.95 to 1.05
// - hopping only master with bus control
// - hop bit: direction 0 0.9, 1 1.1
// - slave without lock uses clock directly
// - stagger allowed only with lock enabled
// - enable low: off, bus writes ignored
`timescale 1ns/10ps
module pwmosc_ctrl
	import pwmosc_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	input  wire logic                enable_pin,
	input  wire logic [RATE_W-1:0]   osc_rate_set_pin,
	input  wire logic                spread_lock_pin,
	input  wire logic                bus_mode,
	input  wire logic                hop_wr,
	input  wire logic                hop_enable_bit,
	input  wire logic                hop_direction_bit,
	input  wire logic                stagger_req,
	input  wire logic                shared_clock_pin_i,
	output logic                     shared_clock_pin_o,
	output logic                     shared_clock_pin_oe,
	output logic                     pwm_out,
	output logic                     pwm_period_tick,
	output logic                     dev_on,
	output logic                     is_master,
	output logic                     spread_on,
	output logic                     lock_on,
	output logic                     stagger_on,
	output logic                     wdog_trip
);
	typedef struct packed {
		pwmosc_state_type          state;
		logic                      master;
		logic                      spread;
		logic                      lock;
		logic                      bus;
		logic [RATE_W-1:0]         rate;
		logic                      hop_en;
		logic                      hop_dir;
		logic [PERMIL_W-1:0]       permil;
		logic                      sweep_up;
		logic [DWELL_W-1:0]        dwell;
		logic [PERIOD_W+FRAC_W-1:0] phase;
		logic                      osc;
		logic                      tick;
		logic                      pwm;
		logic [WDOG_W-1:0]         wdog;
		logic                      trip;
	} pwmosc_ctrl_type;

	pwmosc_ctrl_type st_q;
	pwmosc_ctrl_type st_d;

	logic en_lvl;
	logic clk_lvl;
	logic clk_rise;
	logic [PERIOD_W+FRAC_W-1:0] half_period;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pwmosc_edge u_en (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  (enable_pin),
		.level   (en_lvl),
		.rise    ()
	);

	pwmosc_edge u_clk (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  (shared_clock_pin_i),
		.level   (clk_lvl),
		.rise    (clk_rise)
	);

	// half period in sys cycles, 8 fraction bits:
	// sys_hz * r / const * 1000 / permil / 2
	function automatic logic [PERIOD_W+FRAC_W-1:0] half_cyc(
		input logic [RATE_W-1:0]   r,
		input logic [PERMIL_W-1:0] pm
	);
		logic [95:0] num;
		logic [95:0] den;
		num = 96'(SYS_CLK_HZ) * 96'(r) * 96'(NOMINAL_PERMIL) << FRAC_W;
		den = 96'(RATE_CONST_OHM_HZ) * 96'(pm) * 96'd2;
		half_cyc = (PERIOD_W+FRAC_W)'(num / den);
	endfunction : half_cyc

	assign half_period = half_cyc(st_q.rate, st_q.permil);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		case (st_q.state)
			PWMOSC_OFF: begin
				st_d.osc    = 1'b0;
				st_d.pwm    = 1'b0;
				st_d.phase  = '0;
				st_d.hop_en = 1'b0;
				if (en_lvl) begin
					// straps caught on leaving off; a watchdog trip clears only here
					st_d.trip   = 1'b0;
					st_d.master = (osc_rate_set_pin > RATE_W'(RATE_MASTER_MIN_OHM));
					st_d.rate   = osc_rate_set_pin;
					st_d.spread = spread_lock_pin;
					st_d.lock   = spread_lock_pin;
					st_d.bus    = bus_mode;
					st_d.permil = PERMIL_NOM;
					st_d.sweep_up = 1'b1;
					st_d.dwell  = '0;
					st_d.state  = PWMOSC_RUN;
				end
			end
			PWMOSC_RUN, PWMOSC_STOPPING: begin
				// hop writes only in master with bus control, ignored when off
				if (hop_wr && st_q.master && st_q.bus && st_q.state == PWMOSC_RUN) begin
					st_d.hop_en  = hop_enable_bit;
					st_d.hop_dir = hop_direction_bit;
				end
				if (st_q.master) begin
					// frequency selection: hop wins over spread; a fresh hop write
					// acts at once so permil never lags the hop bits by a cycle
					if (st_d.hop_en) begin
						st_d.permil = st_d.hop_dir ? PERMIL_HHI : PERMIL_HLO;
					end else if (st_q.spread) begin
						st_d.dwell = st_q.dwell + DWELL_W'(1);
						if (st_q.dwell >= DWELL_W'(SPREAD_DWELL_CYC - 1)) begin
							st_d.dwell = '0;
							if (st_q.permil < PERMIL_SLO) begin
								st_d.permil   = PERMIL_SLO;
								st_d.sweep_up = 1'b1;
							end else if (st_q.sweep_up) begin
								if (st_q.permil >= PERMIL_SHI) begin
									st_d.sweep_up = 1'b0;
									st_d.permil   = st_q.permil - PERMIL_W'(SPREAD_STEP_PERMIL);
								end else begin
									st_d.permil = st_q.permil + PERMIL_W'(SPREAD_STEP_PERMIL);
								end
							end else begin
								if (st_q.permil <= PERMIL_SLO) begin
									st_d.sweep_up = 1'b1;
									st_d.permil   = st_q.permil + PERMIL_W'(SPREAD_STEP_PERMIL);
								end else begin
									st_d.permil = st_q.permil - PERMIL_W'(SPREAD_STEP_PERMIL);
								end
							end
						end
						// back from a hop: restart the sweep at nominal
						if (st_q.permil < PERMIL_SLO || st_q.permil > PERMIL_SHI) begin
							st_d.permil   = PERMIL_NOM;
							st_d.sweep_up = 1'b1;
							st_d.dwell    = '0;
						end
					end else begin
						st_d.permil = PERMIL_NOM;
					end
					// internal oscillator: toggle at each half period
					st_d.phase = st_q.phase + (PERIOD_W+FRAC_W)'(1 << FRAC_W);
					if (st_q.phase + (PERIOD_W+FRAC_W)'(1 << FRAC_W) >= half_period) begin
						st_d.phase = st_q.phase + (PERIOD_W+FRAC_W)'(1 << FRAC_W) - half_period;
						st_d.osc   = ~st_q.osc;
						st_d.tick  = ~st_q.osc;
					end
					st_d.pwm = st_q.osc;
					if (!en_lvl) begin
						st_d.state = PWMOSC_OFF;
					end
				end else begin
					// slave: switching clock follows incoming clock
					st_d.osc  = clk_lvl;
					st_d.pwm  = clk_lvl;
					st_d.tick = clk_rise;
					if (!en_lvl && st_q.state == PWMOSC_RUN) begin
						st_d.state = PWMOSC_STOPPING;
						st_d.wdog  = '0;
					end
					if (st_q.state == PWMOSC_STOPPING) begin
						// finish shutdown on a clock edge, or trip on silence
						if (clk_rise) begin
							st_d.state = PWMOSC_OFF;
						end else if (st_q.wdog >= WDOG_W'(WDOG_CYC - 1)) begin
							st_d.state = PWMOSC_OFF;
							st_d.trip  = 1'b1;
						end else begin
							st_d.wdog = st_q.wdog + WDOG_W'(1);
						end
					end
				end
			end
			default: begin
				st_d.state = PWMOSC_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q          <= '0;
			st_q.state    <= PWMOSC_OFF;
			st_q.permil   <= PERMIL_NOM;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign shared_clock_pin_o  = st_q.osc & st_q.master;
	assign shared_clock_pin_oe = (st_q.state != PWMOSC_OFF) & st_q.master;
	assign pwm_out             = st_q.pwm;
	assign pwm_period_tick     = st_q.tick;
	assign dev_on              = (st_q.state != PWMOSC_OFF);
	assign is_master           = st_q.master;
	assign spread_on           = dev_on & st_q.master & st_q.spread;
	assign lock_on             = dev_on & ~st_q.master & st_q.lock;
	assign stagger_on          = lock_on & stagger_req;
	assign wdog_trip           = st_q.trip;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_slave_no_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
		!st_q.master |-> !shared_clock_pin_oe)
		else $error("slave drives shared clock");
	chk_master_drives: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q.master && dev_on) |-> shared_clock_pin_oe)
		else $error("master not driving shared clock");
	chk_spread_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && st_q.master && st_q.spread && !st_q.hop_en && $past(dev_on))
		|-> (st_q.permil >= PERMIL_SLO && st_q.permil <= PERMIL_SHI))
		else $error("spread outside range");
	chk_hop_value: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && st_q.master && st_q.hop_en) |=> (!st_q.hop_en || !dev_on ||
		st_q.permil == (st_q.hop_dir ? PERMIL_HHI : PERMIL_HLO)))
		else $error("hop frequency wrong");
	chk_hop_master_only: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q.hop_en && dev_on) |-> (st_q.master && st_q.bus))
		else $error("hop outside master bus mode");
	chk_off_no_hop: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!dev_on && $past(!dev_on)) |-> !st_q.hop_en)
		else $error("hop bit kept while off");
	chk_wdog_trip: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q.state == PWMOSC_STOPPING && st_q.wdog >= WDOG_W'(WDOG_CYC - 1) && !clk_rise)
		|=> (!dev_on && wdog_trip))
		else $error("watchdog did not force off");
	chk_slave_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && !st_q.master && $past(dev_on)) |-> (pwm_out == $past(clk_lvl)))
		else $error("slave pwm not following clock");
	chk_stagger_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
		stagger_on |-> (lock_on && !st_q.master))
		else $error("stagger without lock");

	// strap decode, seen in the first cycle out of off
	chk_strap_master: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && !$past(dev_on) &&
		$past(osc_rate_set_pin) > RATE_W'(RATE_MASTER_MIN_OHM))
		|-> (is_master && shared_clock_pin_oe))
		else $error("master strap not decoded");
	chk_strap_slave: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && !$past(dev_on) && $past(osc_rate_set_pin) == '0)
		|-> (!is_master && !shared_clock_pin_oe))
		else $error("slave strap not decoded");
	chk_spread_nominal: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && st_q.master && !st_q.spread && !st_q.hop_en)
		|-> (st_q.permil == PERMIL_NOM))
		else $error("no spread but frequency moved");

	// hop bit writes: taken, refused outside master bus mode, refused while off
	chk_hop_take: assert property (@(posedge clk_sys) disable iff (!rstn)
		(hop_wr && st_q.state == PWMOSC_RUN && st_q.master && st_q.bus)
		|=> (st_q.hop_en == $past(hop_enable_bit) &&
		st_q.hop_dir == $past(hop_direction_bit)))
		else $error("hop write not taken");
	chk_hop_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		(hop_wr && !(st_q.master && st_q.bus) && !st_q.hop_en) |=> !st_q.hop_en)
		else $error("hop taken outside master bus mode");
	chk_hop_while_off: assert property (@(posedge clk_sys) disable iff (!rstn)
		(hop_wr && !dev_on) |=> !st_q.hop_en)
		else $error("hop taken while off");

	// slave shutdown and period tick
	chk_stop_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_q.state == PWMOSC_RUN && !st_q.master && !en_lvl)
		|=> (st_q.state == PWMOSC_STOPPING && st_q.wdog == '0))
		else $error("slave did not arm watchdog");
	chk_trip_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wdog_trip && !dev_on) |=> (wdog_trip || dev_on))
		else $error("trip flag lost while off");
	chk_slave_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dev_on && !st_q.master && $past(dev_on))
		|-> (pwm_period_tick == $past(clk_rise)))
		else $error("slave period tick not on clock edge");

endmodule : pwmosc_ctrl

// >>> pwmosc_clk_src.sv
// pwmosc far side model: external clock source on the shared clock pin
`timescale 1ns/10ps
module pwmosc_clk_src (
	input  wire logic run,
	output logic      clk_out
);
	// ------------------------------------------------
	// clock of 160 ns, held low while stopped
	// ------------------------------------------------
	initial begin
		clk_out = 1'b0;
		forever begin
			#80;
			clk_out = run ? ~clk_out : 1'b0;
		end
	end
endmodule : pwmosc_clk_src

// >>> pwmosc_ctrl_bench.sv
// pwmosc bench: master, hop, spread, slave and watchdog sequences
`timescale 1ns/10ps
module pwmosc_ctrl_bench;
	import pwmosc_pkg::*;
	logic              clk_sys = 1'b0, rstn = 1'b0, enable_pin = 1'b0, src_run = 1'b0;
	logic              spread_lock_pin = 1'b0, bus_mode = 1'b0, stagger_req = 1'b0;
	logic              hop_wr = 1'b0, hop_en = 1'b0, hop_dir = 1'b0;
	logic [RATE_W-1:0] rate = '0;
	logic              src_clk, pin_o, pin_oe, pwm_out, tick, dev_on;
	logic              is_master, spread_on, lock_on, stagger_on, wdog_trip;
	wire               pin_w = pin_oe ? pin_o : src_clk; // wire level from both drivers
	int                n_mismatch = 0, num_checks = 0, p, k, i;
	int                tab [4][4] = '{'{1, 0, 900, 0}, '{0, 0, 1000, 0}, '{1, 1, 1100, 0},
	                                  '{0, 1, 1000, 1}};
	always #10 clk_sys = ~clk_sys;
	pwmosc_clk_src i_pwmosc_clk_src (.run(src_run), .clk_out(src_clk));
	pwmosc_ctrl i_pwmosc_ctrl (.clk_sys(clk_sys), .rstn(rstn), .enable_pin(enable_pin),
		.osc_rate_set_pin(rate), .spread_lock_pin(spread_lock_pin), .bus_mode(bus_mode),
		.hop_wr(hop_wr), .hop_enable_bit(hop_en), .hop_direction_bit(hop_dir),
		.stagger_req(stagger_req), .shared_clock_pin_i(pin_w), .shared_clock_pin_o(pin_o),
		.shared_clock_pin_oe(pin_oe), .pwm_out(pwm_out), .pwm_period_tick(tick),
		.dev_on(dev_on), .is_master(is_master), .spread_on(spread_on), .lock_on(lock_on),
		.stagger_on(stagger_on), .wdog_trip(wdog_trip));
	// ------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	// cycles between two period ticks, bounded
	task automatic period(output int n);
		for (k = 0; k < 3000 && tick !== 1'b1; k++) cyc(1);
		if (k == 3000) begin
			n_mismatch++;
			stop_test();
		end
		cyc(1);
		for (n = 1; n < 3000 && tick !== 1'b1; n++) cyc(1);
	endtask : period
	task automatic power(input logic [RATE_W-1:0] r, input logic s, input logic b);
		enable_pin = 1'b0;
		cyc(20);
		rate = r;
		spread_lock_pin = s;
		bus_mode = b;
		cyc(1);
		enable_pin = 1'b1;
		cyc(6);
	endtask : power
	task automatic hop(input logic e, input logic d);
		hop_en = e;
		hop_dir = d;
		hop_wr = 1'b1;
		cyc(1);
		hop_wr = 1'b0;
	endtask : hop
	// exp period in sys cycles for 39k and a permil factor
	function automatic int mper(input int pm);
		return (39000 * 50 * 1000) / (12450 * pm);
	endfunction : mper
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		cyc(6);
		chk("dev_on in reset", 1'b0, dev_on);
		chk("oe in reset", 1'b0, pin_oe);
		rstn = 1'b1;
		power(24'h009858, 1'b0, 1'b0);
		chk("is_master", 1'b1, is_master);
		chk("pin oe master", 1'b1, pin_oe);
		chk("spread off", 1'b0, spread_on);
		chk("lock master", 1'b0, lock_on);
		period(p);
		chk_rng("nominal period", mper(1000) - 2, mper(1000) + 2, p);
		chk("pin drives osc", 1'b1, pin_o);
		cyc(1);
		chk("pwm follows osc", 1'b1, pwm_out);
		hop(1'b1, 1'b1);
		period(p);
		period(p);
		chk_rng("hop without bus", mper(1000) - 2, mper(1000) + 2, p);
		rate = '0;
		cyc(4);
		chk("strap held", 1'b1, is_master);
		power(24'h009858, 1'b0, 1'b1);
		for (i = 0; i < 4; i++) begin
			if (tab[i][3] != 0) begin
				enable_pin = 1'b0;
				cyc(20);
				hop(1'b1, 1'b0);
				enable_pin = 1'b1;
				cyc(6);
			end else hop(tab[i][0][0], tab[i][1][0]);
			period(p);
			period(p);
			chk_rng("hop period", mper(tab[i][2]) - 2, mper(tab[i][2]) + 2, p);
		end
		power(24'h009858, 1'b1, 1'b1);
		chk("spread on", 1'b1, spread_on);
		period(p);
		chk_rng("spread period", mper(1050) - 2, mper(950) + 2, p);
		// twenty sweep steps upward from nominal
		cyc(20 * SPREAD_DWELL_CYC);
		period(p);
		chk_rng("spread swept", mper(1025), mper(1015), p);
		src_run = 1'b1;
		power('0, 1'b0, 1'b0);
		stagger_req = 1'b1;
		cyc(4);
		chk("slave", 1'b0, is_master);
		chk("pin oe slave", 1'b0, pin_oe);
		chk("lock off", 1'b0, lock_on);
		chk("stagger no lock", 1'b0, stagger_on);
		period(p);
		chk_rng("slave period", 7, 9, p);
		chk("slave pwm", 1'b1, pwm_out);
		chk("slave pin out", 1'b0, pin_o);
		power('0, 1'b1, 1'b0);
		cyc(4);
		chk("lock on", 1'b1, lock_on);
		chk("spread slave", 1'b0, spread_on);
		chk("stagger lock", 1'b1, stagger_on);
		enable_pin = 1'b0;
		cyc(20);
		chk("slave off", 1'b0, dev_on);
		chk("no trip", 1'b0, wdog_trip);
		power('0, 1'b0, 1'b0);
		src_run = 1'b0;
		enable_pin = 1'b0;
		for (p = 0; p < 1200 && dev_on !== 1'b0; p++) cyc(1);
		chk_rng("watchdog time", WDOG_CYC - 10, WDOG_CYC + 10, p);
		chk("trip", 1'b1, wdog_trip);
		cyc(4);
		chk("trip held", 1'b1, wdog_trip);
		power('0, 1'b0, 1'b0);
		chk("trip cleared", 1'b0, wdog_trip);
		stop_test();
	end
endmodule : pwmosc_ctrl_bench
